// [src/arop_pkg.sv]
// Constants for the converter result output port.
// Assumes a 100 MHz system clock; the link clock is the converter clock.
package arop_pkg;
  localparam int unsigned RES_W          = 12;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned NIB_W          = 4;
  localparam int unsigned SYNC_STAGES    = 2;
  localparam int unsigned CLK_PERIOD_NS  = 10;
  // Internal oscillator period, in ns (plain default)
  localparam int unsigned INT_OSC_PERIOD_NS = 400;
  localparam int unsigned INT_OSC_HALF_CYC  =
    (INT_OSC_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int unsigned OSC_CNT_W      = 8;
  localparam int unsigned BIT_CNT_W      = 4;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'hb;
  localparam logic [RES_W-1:0] RES_RST   = 12'h000;
  localparam logic [NIB_W-1:0] UPPER_LOW = 4'h0;
  // Parallel-mode positions of the shared serial pins and the msb pin
  localparam int unsigned POS_STRB = 10;
  localparam int unsigned POS_SCLK = 9;
  localparam int unsigned POS_SDAT = 8;
  localparam int unsigned POS_MSB  = 11;
  typedef enum logic {ARP_IDLE, ARP_SHIFT} arop_link_e;
endpackage : arop_pkg

// [src/arop_sync.sv]
// Two-stage level synchroniser, any width.
// Assumes each bit is a slow level or a toggle.
`timescale 1ns/1ps
`default_nettype none
module arop_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule : arop_sync
`default_nettype wire

// [src/arop_top.sv]
// Result output port: parallel, byte and serial forms of a 12-bit result.
// Assumes result_in and conv_active_in come from logic on clock_in, and that
// the clock-pin strap (ext_clk_at_vss_in) is static while running.
//
// Contract
// R1 - Data lanes enable only while read strobe and chip select are both low.
// R2 - Active-low status output shows busy converting or conversion finished.
// R3 - External clock pin clocks converter; pin tied to negative rail uses oscillator.
// R4 - In 12-bit mode the shared msb pin drives result bit 11.
// R5 - In byte mode the shared msb pin is the host's byte select input.
// R6 - Byte mode, select low: lanes carry result bits 7 to 0.
// R7 - Byte mode, select high: lanes carry the upper byte of the result.
// R8 - In 12-bit mode strobe, clock and data pins carry bits 10, 9, 8.
// R9 - Serial bit clock is the gated converter clock, internal or external; here it is that clock halved.
// R10 - Format pin at negative rail: serial bit clock runs continuously.
// R11 - Format pin at ground: serial bit clock stops after a transfer.
// R12 - Serial bit clock is open drain: pulled low, released for high.
// R13 - Serial data is open drain, paired with bit clock and frame strobe.
// R14 - Data bit stands valid at each bit-clock falling edge while strobe low.
// R15 - Lanes stay high impedance unless chip select and read both asserted.
// R16 - Upper-byte read gives zeros on top four lanes, bits 11-8 below.
// R17 - Frame strobe low for each 12-bit serial transfer, high afterwards.
// R18 - Host keeps byte select steady during a byte read.
`timescale 1ns/1ps
`default_nettype none
module arop_top
  import arop_pkg::*;
(
  // System clock and reset
  input  wire logic             clock_in,
  input  wire logic             rstn_in,
  // Converter clock pin and its strap
  input  wire logic             ext_clk_in,
  input  wire logic             ext_clk_at_vss_in,
  // Format select pin, decoded: high, or at negative rail
  input  wire logic             fmt_12bit_in,
  input  wire logic             fmt_neg_in,
  // Conversion core
  input  wire logic [RES_W-1:0] result_in,
  input  wire logic             result_valid_in,
  input  wire logic             conv_active_in,
  // Host bus pins
  input  wire logic             cs_n_in,
  input  wire logic             rd_n_in,
  input  wire logic             high_byte_select_in,
  output logic                  conv_busy_n_out,
  output logic [RES_W-1:0]      lanes_out,
  output logic                  lanes_low_oe_out,
  output logic                  lanes_high_oe_out,
  // Serial pins, open drain
  output logic                  serial_frame_strobe_n_out,
  output logic                  serial_frame_strobe_n_oe_out,
  output logic                  serial_clk_out,
  output logic                  serial_clk_oe_out,
  output logic                  serial_data_out,
  output logic                  serial_data_oe_out,
  // Oscillator observation
  output logic                  int_osc_out
);

  // ---------------- System domain ----------------
  logic [3:0]           pin_s;
  logic [RES_W-1:0]     result_q;
  logic [RES_W-1:0]     tx_word_q;
  logic                 req_q;
  logic                 ack_s;
  logic [OSC_CNT_W-1:0] osc_cnt_q;
  logic                 osc_q;
  logic [RES_W-1:0]     lanes_q;
  logic                 low_oe_q;
  logic                 high_oe_q;
  logic                 busy_n_q;
  logic                 ack_t_q;

  arop_sync #(.W(4)) u_pin_sync (
    .clk_in  (clock_in),
    .rstn_in (rstn_in),
    .d_in    ({cs_n_in, rd_n_in, high_byte_select_in, fmt_12bit_in}),
    .q_out   (pin_s)
  );

  wire cs_n_s      = pin_s[3];
  wire rd_n_s      = pin_s[2];
  wire hbs_s       = pin_s[1];
  wire par_mode_s  = pin_s[0];
  wire read_en     = !cs_n_s && !rd_n_s;                      // R1 R15
  wire link_free   = (req_q == ack_s);
  wire launch      = result_valid_in && !par_mode_s && link_free;
  wire osc_wrap    = (osc_cnt_q == OSC_CNT_W'(INT_OSC_HALF_CYC - 1));

  // Byte-mode lane selection
  wire [BYTE_W-1:0] byte_lo  = result_q[BYTE_W-1:0];               // R6
  wire [BYTE_W-1:0] byte_hi  = {UPPER_LOW, result_q[RES_W-1:BYTE_W]}; // R7 R16
  wire [BYTE_W-1:0] byte_sel = hbs_s ? byte_hi : byte_lo;            // R5
  wire [RES_W-1:0]  lanes_d  =
    par_mode_s ? result_q : {{NIB_W{1'b0}}, byte_sel};               // R4 R8

  // Latest result; the word in flight to the link stays frozen
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      result_q <= RES_RST;
    end else if (result_valid_in) begin
      result_q <= result_in;
    end
  end

  // Word for the link; frozen until the acknowledge returns
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tx_word_q <= RES_RST;
    end else if (launch) begin
      tx_word_q <= result_in;
    end
  end

  // Request toggle towards the link; one frame at a time
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      req_q <= 1'b0;
    end else if (launch) begin
      req_q <= ~req_q;
    end
  end

  // Host read lanes; selection follows the synced byte select
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lanes_q <= RES_RST;
    end else begin
      lanes_q <= lanes_d;                                   // R6 R7
    end
  end

  // Lanes 7..0 enable; two sync stages plus this register
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      low_oe_q <= 1'b0;
    end else begin
      low_oe_q <= read_en;                                  // R1 R15
    end
  end

  // High lanes only in 12-bit mode since bit 11 is an input
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      high_oe_q <= 1'b0;
    end else begin
      high_oe_q <= read_en && par_mode_s;                   // R4 R5 R8 R15
    end
  end

  // Status pin low while converting
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_n_q <= 1'b1;
    end else begin
      busy_n_q <= !conv_active_in;                          // R2
    end
  end

  // Internal oscillator, used when the clock pin is tied low
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      osc_cnt_q <= '0;
      osc_q     <= 1'b0;
    end else if (osc_wrap) begin
      osc_cnt_q <= '0;
      osc_q     <= ~osc_q;                                  // R3
    end else begin
      osc_cnt_q <= osc_cnt_q + OSC_CNT_W'(1);
    end
  end

  assign conv_busy_n_out   = busy_n_q;
  assign lanes_out         = lanes_q;
  assign lanes_low_oe_out  = low_oe_q;
  assign lanes_high_oe_out = high_oe_q;
  assign int_osc_out       = osc_q;

  // ---------------- Link domain ----------------
  // Glitch-free switching is not attempted; the strap must be static.
  wire conv_clk = ext_clk_at_vss_in ? osc_q : ext_clk_in;   // R3 R9

  logic                 link_rstn;
  logic [2:0]           link_s;
  arop_link_e           state_q;
  logic [RES_W-1:0]     shift_q;
  logic [BIT_CNT_W-1:0] bit_q;
  logic                 sclk_q;
  logic                 strb_n_q;
  logic                 sdat_q;
  logic                 req_seen_q;
  logic                 sclk_oe_q;
  logic                 strb_oe_q;
  logic                 sdat_oe_q;

  // Reset leaves the link domain only on its own clock
  arop_sync #(.W(1)) u_link_rst (
    .clk_in  (conv_clk),
    .rstn_in (rstn_in),
    .d_in    (1'b1),
    .q_out   (link_rstn)
  );

  arop_sync #(.W(3)) u_link_sync (
    .clk_in  (conv_clk),
    .rstn_in (rstn_in),
    .d_in    ({req_q, fmt_neg_in, fmt_12bit_in}),
    .q_out   (link_s)
  );

  // Acknowledge toggle back; the word stays frozen until it returns
  arop_sync #(.W(1)) u_ack_sync (
    .clk_in  (clock_in),
    .rstn_in (rstn_in),
    .d_in    (req_seen_q),
    .q_out   (ack_s)
  );

  wire req_s      = link_s[2];
  wire cont_s     = link_s[1];
  wire par_link_s = link_s[0];
  wire idle_run   = cont_s && !par_link_s;                  // R10 R11
  wire sclk_run   = (state_q == ARP_SHIFT) || idle_run;     // R9 R10
  wire sclk_d     = sclk_run ? !sclk_q : 1'b1;              // R11
  wire new_req    = (req_s != req_seen_q);
  // Start where the bit clock goes or stays high, so the first fall carries bit 11
  wire start      = (state_q == ARP_IDLE) && new_req && sclk_d;
  wire rise_next  = !sclk_q;
  wire last_bit   = (bit_q == LAST_BIT);
  wire shift_step = (state_q == ARP_SHIFT) && rise_next && !last_bit;
  wire frame_end  = (state_q == ARP_SHIFT) && rise_next && last_bit;
  wire strb_n_d   = start ? 1'b0 : (frame_end ? 1'b1 : strb_n_q); // R17
  wire sdat_d     = start      ? tx_word_q[POS_MSB] :       // R13
                    shift_step ? shift_q[POS_MSB]   :       // R14
                    frame_end  ? 1'b1 : sdat_q;

  // Frame sequencer
  always_ff @(posedge conv_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      state_q <= ARP_IDLE;
    end else begin
      unique case (state_q)
        ARP_IDLE: begin
          if (start) begin
            state_q <= ARP_SHIFT;
          end
        end
        ARP_SHIFT: begin
          if (frame_end) begin
            state_q <= ARP_IDLE;                            // R11
          end
        end
      endcase
    end
  end

  // Request accepted; doubles as the acknowledge toggle
  always_ff @(posedge conv_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      req_seen_q <= 1'b0;
    end else if (start) begin
      req_seen_q <= req_s;
    end
  end

  // Word capture, then one shift per bit-clock rise except the frame's last
  always_ff @(posedge conv_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      shift_q <= RES_RST;
    end else if (start) begin
      shift_q <= tx_word_q << 1;
    end else if (shift_step) begin
      shift_q <= shift_q << 1;
    end
  end

  // Bit counter, twelve bits a frame
  always_ff @(posedge conv_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      bit_q <= '0;
    end else if (start) begin
      bit_q <= '0;
    end else if (shift_step) begin
      bit_q <= bit_q + BIT_CNT_W'(1);
    end
  end

  // Data pin; changes only on edges where the bit clock goes or stays high
  always_ff @(posedge conv_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      sdat_q    <= 1'b1;
      sdat_oe_q <= 1'b0;
    end else begin
      sdat_q    <= sdat_d;
      sdat_oe_q <= !sdat_d;                                 // R13
    end
  end

  // Bit clock: gated converter clock halved, held high when stopped
  always_ff @(posedge conv_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      sclk_q    <= 1'b1;
      sclk_oe_q <= 1'b0;
    end else begin
      sclk_q    <= sclk_d;                                  // R9 R10
      sclk_oe_q <= !sclk_d;                                 // R12
    end
  end

  // Frame strobe spans all twelve bits
  always_ff @(posedge conv_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      strb_n_q  <= 1'b1;
      strb_oe_q <= 1'b0;
    end else begin
      strb_n_q  <= strb_n_d;                                // R17
      strb_oe_q <= !strb_n_d;                               // R17
    end
  end

  // Open drain: enable pulls low, release gives high via pull-up
  assign serial_clk_out               = 1'b0;
  assign serial_clk_oe_out            = sclk_oe_q;          // R12
  assign serial_data_out              = 1'b0;
  assign serial_data_oe_out           = sdat_oe_q;          // R13
  assign serial_frame_strobe_n_out    = 1'b0;
  assign serial_frame_strobe_n_oe_out = strb_oe_q;          // R17

endmodule : arop_top
`default_nettype wire

// [test/adc_result_output_port_test.sv]
// Bench for the result output port: host reads, serial frames, status.
// Assumes pull-ups on the serial pins and the receiver model beside them.
`timescale 1ns/1ps
`default_nettype none
module adc_result_output_port_test;
  import arop_pkg::*;
  logic clock_in = 0, rstn_in = 0, ext_clk_in = 0, ext_clk_at_vss_in = 0;
  logic fmt_12bit_in = 1, fmt_neg_in = 0, result_valid_in = 0, conv_active_in = 0;
  logic cs_n_in = 1, rd_n_in = 1, high_byte_select_in = 0;
  logic [RES_W-1:0] result_in = '0, lanes_out, v, rx_word;
  logic conv_busy_n_out, lanes_low_oe_out, lanes_high_oe_out, int_osc_out;
  logic serial_frame_strobe_n_out, serial_frame_strobe_n_oe_out, serial_clk_out;
  logic serial_clk_oe_out, serial_data_out, serial_data_oe_out;
  logic [7:0] rx_n, rx_f, m;
  int fails = 0, tests_run = 0;
  always #5 clock_in = ~clock_in;
  initial begin
    #3;
    forever #40 ext_clk_in = ~ext_clk_in;
  end
  arop_top i_dut (.*);
  arop_rx_model i_rx (.rstn_in(rstn_in), .strobe_n_in(!serial_frame_strobe_n_oe_out),
    .sclk_in(!serial_clk_oe_out), .serial_data_out_in(!serial_data_oe_out), .word_out(rx_word),
    .frames_out(rx_n), .falls_out(rx_f));
  task automatic check(input logic [11:0] s, input logic [11:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic wt(input int n);
    repeat (n) @(negedge clock_in);
  endtask : wt
  // Select held steady for the whole read
  task automatic rd(input logic sel);
    @(negedge clock_in);
    {high_byte_select_in, cs_n_in, rd_n_in} = {sel, 2'b00};
    wt(5);
    v = lanes_out;
    check(12'({lanes_high_oe_out, lanes_low_oe_out}), 12'({fmt_12bit_in, 1'b1}));
    {cs_n_in, rd_n_in} = 2'b11;
    wt(5);
    check(12'({lanes_high_oe_out, lanes_low_oe_out}), 12'h000);
  endtask : rd
  task automatic put(input logic [11:0] r);
    wt(250);
    m = rx_n;
    result_in = r;
    result_valid_in = 1;
    @(negedge clock_in);
    result_valid_in = 0;
  endtask : put
  task automatic frame(input logic [11:0] r);
    put(r);
    for (int i = 0; i < 3000 && rx_n == m; i++) @(negedge clock_in);
    check(rx_word, r);
  endtask : frame
  task automatic reset_dut();
    rstn_in = 1;
    #1;
    rstn_in = 0;
    wt(20);
    rstn_in = 1;
    wt(4);
  endtask : reset_dut
  initial begin
    #300000;
    fails++;
    tally_and_finish();
  end
  initial begin
    reset_dut();
    put(12'ha5c);
    rd(0);
    check(v, 12'ha5c);
    wt(300);
    check(12'(rx_n), 12'(m));
    $display("parallel word done");
    fmt_12bit_in = 0;
    frame(12'h9e7);
    rd(0);
    check(12'(v[7:0]), 12'h0e7);
    rd(1);
    check(12'(v[7:0]), 12'h009);
    m = rx_f;
    wt(100);
    check(12'(rx_f), 12'(m));
    $display("byte and gated serial done");
    fmt_neg_in = 1;
    frame(12'h3c1);
    m = rx_f;
    wt(100);
    check(12'(rx_f != m), 12'h001);
    $display("continuous serial done");
    conv_active_in = 1;
    wt(2);
    check(12'(conv_busy_n_out), 12'h000);
    conv_active_in = 0;
    wt(2);
    check(12'(conv_busy_n_out), 12'h001);
    $display("status done");
    {fmt_neg_in, ext_clk_at_vss_in} = 2'b01;
    reset_dut();
    frame(12'h5a6);
    m = 8'(int_osc_out);
    wt(INT_OSC_HALF_CYC);
    check(12'(int_osc_out), 12'(!m[0]));
    $display("oscillator serial done");
    tally_and_finish();
  end
endmodule : adc_result_output_port_test
`default_nettype wire

// [test/arop_rx_model.sv]
// Host serial receiver: shifts data on bit-clock falls inside a frame.
// Assumes pin levels with pull-ups are resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module arop_rx_model
  import arop_pkg::*;
(
  input  wire logic             rstn_in,
  input  wire logic             strobe_n_in,
  input  wire logic             sclk_in,
  input  wire logic             serial_data_out_in,
  output logic      [RES_W-1:0] word_out,
  output logic      [7:0]       frames_out,
  output logic      [7:0]       falls_out
);
  logic [RES_W-1:0] sh;
  always @(negedge sclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sh <= '0;
      falls_out <= '0;
    end else begin
      falls_out <= falls_out + 8'h01;
      if (!strobe_n_in) sh <= {sh[RES_W-2:0], serial_data_out_in};
    end
  end
  always @(posedge strobe_n_in or negedge rstn_in) begin
    if (!rstn_in) begin
      word_out <= '0;
      frames_out <= '0;
    end else begin
      word_out <= sh;
      frames_out <= frames_out + 8'h01;
    end
  end
endmodule : arop_rx_model
`default_nettype wire

// [test/arop_top_asserts.sv]
// Checker for the result output port, bound to arop_top.
// Assumes the inputs change at the falling edge of clock_in.
`timescale 1ns/1ps
`default_nettype none
module arop_top_asserts
  import arop_pkg::*;
(
  input wire logic clock_in, rstn_in,
  input wire logic fmt_12bit_in, fmt_neg_in, result_valid_in, conv_active_in,
  input wire logic [RES_W-1:0] result_in,
  input wire logic cs_n_in, rd_n_in, high_byte_select_in, conv_busy_n_out,
  input wire logic [RES_W-1:0] lanes_out,
  input wire logic lanes_low_oe_out, lanes_high_oe_out,
  input wire logic serial_frame_strobe_n_out, serial_frame_strobe_n_oe_out,
  input wire logic serial_clk_out, serial_clk_oe_out,
  input wire logic serial_data_out, serial_data_oe_out
);
  logic [RES_W-1:0] res_q;
  logic [10:0]      frm_q;
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) res_q <= RES_RST;
    else if (result_valid_in) res_q <= result_in;
  end
  // Frame length in system cycles; oscillator frames are the longest
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) frm_q <= 11'h000;
    else frm_q <= serial_frame_strobe_n_oe_out ? frm_q + 11'h001 : 11'h000;
  end
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  chk_lanes_idle: assert property (cs_n_in[*5] |-> !lanes_low_oe_out && !lanes_high_oe_out)
    else $error("lanes enabled without chip select");
  chk_read_enable: assert property ((!cs_n_in && !rd_n_in)[*5] |-> lanes_low_oe_out)
    else $error("lanes not enabled during read");
  chk_byte_no_high: assert property ((!fmt_12bit_in)[*5] |-> !lanes_high_oe_out)
    else $error("upper lanes enabled in byte mode");
  chk_busy_follows: assert property ($changed(conv_active_in) |=> conv_busy_n_out == !$past(conv_active_in))
    else $error("status output wrong");
  chk_low_byte: assert property ((!fmt_12bit_in && !high_byte_select_in && !result_valid_in)[*5]
    ##0 lanes_low_oe_out |-> lanes_out[7:0] == res_q[7:0])
    else $error("low byte wrong");
  chk_high_byte: assert property ((!fmt_12bit_in && high_byte_select_in && !result_valid_in)[*5]
    ##0 lanes_low_oe_out |-> lanes_out[7:0] == {UPPER_LOW, res_q[11:8]})
    else $error("high byte wrong");
  chk_word_out: assert property ((fmt_12bit_in && !result_valid_in)[*5]
    ##0 lanes_low_oe_out |-> lanes_out == res_q)
    else $error("parallel word wrong");
  chk_gated_clock: assert property ((!fmt_neg_in)[*8] ##0 !serial_frame_strobe_n_oe_out
    |-> !serial_clk_oe_out)
    else $error("bit clock runs outside frame");
  chk_data_release: assert property (!serial_frame_strobe_n_oe_out |-> !serial_data_oe_out)
    else $error("data driven outside frame");
  chk_frame_length: assert property (frm_q < 11'd1000)
    else $error("frame strobe held too long");
  chk_open_drain: assert property (!serial_clk_out && !serial_data_out
    && !serial_frame_strobe_n_out)
    else $error("serial pin driven high");
  cover property (lanes_low_oe_out && high_byte_select_in);
  cover property ($fell(serial_frame_strobe_n_oe_out));
  cover property ($rose(conv_busy_n_out));
endmodule : arop_top_asserts
bind arop_top arop_top_asserts i_chk (.*);
`default_nettype wire
